// ---- mbrw_pkg.sv ----
package mbrw_pkg;

  // ***********************************************************
  // clock and time base
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CW       = 16;
  localparam int CNT_W         = 21;

  // ***********************************************************
  // timeout figures in milliseconds
  // ***********************************************************
  localparam logic [CNT_W-1:0] TMO_0P5S_MS = 21'd500;
  localparam logic [CNT_W-1:0] TMO_1S_MS   = 21'd1000;
  localparam logic [CNT_W-1:0] TMO_2S_MS   = 21'd2000;
  localparam logic [CNT_W-1:0] TMO_5S_MS   = 21'd5000;
  localparam logic [CNT_W-1:0] TMO_10S_MS  = 21'd10000;
  localparam logic [CNT_W-1:0] TMO_30S_MS  = 21'd30000;
  localparam logic [CNT_W-1:0] TMO_1M_MS   = 21'd60000;
  localparam logic [CNT_W-1:0] TMO_2M_MS   = 21'd120000;
  localparam logic [CNT_W-1:0] TMO_5M_MS   = 21'd300000;
  localparam logic [CNT_W-1:0] TMO_10M_MS  = 21'd600000;
  localparam logic [CNT_W-1:0] TMO_30M_MS  = 21'd1800000;
  localparam logic [CNT_W-1:0] TMO_NONE_MS = 21'd0;

  // boot-time / delay choices: codes 0 and 7 = disabled (or no delay)
  localparam logic [CNT_W-1:0] LONG_TMO_MS [8] = '{TMO_NONE_MS, TMO_30S_MS, TMO_1M_MS,
                                                   TMO_2M_MS, TMO_5M_MS, TMO_10M_MS,
                                                   TMO_30M_MS, TMO_NONE_MS};
  // stage choices, codes 0..7
  localparam logic [CNT_W-1:0] STAGE_TMO_MS [8] = '{TMO_0P5S_MS, TMO_1S_MS, TMO_2S_MS,
                                                    TMO_5S_MS, TMO_10S_MS, TMO_30S_MS,
                                                    TMO_1M_MS, TMO_2M_MS};

  // ***********************************************************
  // reset values and last stage index
  // ***********************************************************
  localparam logic [CNT_W-1:0] CNT_RST   = 21'h00_0000;
  localparam logic [1:0]       STAGE_RST = 2'h0;
  localparam logic [1:0]       STAGE_LST = 2'h2;

  // ***********************************************************
  // enumerations
  // ***********************************************************
  typedef enum logic [1:0] {
    MBRW_MODE_OFF    = 2'b00,
    MBRW_MODE_ONCE   = 2'b01,
    MBRW_MODE_SINGLE = 2'b10,
    MBRW_MODE_REPEAT = 2'b11
  } mbrw_mode_t;

  typedef enum logic [2:0] {
    MBRW_EV_OFF  = 3'b000,
    MBRW_EV_NMI  = 3'b001,
    MBRW_EV_ACPI = 3'b010,
    MBRW_EV_RST  = 3'b011,
    MBRW_EV_PWR  = 3'b100
  } mbrw_ev_t;

  typedef enum logic [1:0] {
    MBRW_RT_OFF   = 2'b00,
    MBRW_RT_DELAY = 2'b01,
    MBRW_RT_STAGE = 2'b10
  } mbrw_rt_t;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic [2:0] tmo_sel;
    logic       stop_en;
  } mbrw_post_cfg_t;

  typedef struct packed {
    mbrw_mode_t     mode;
    logic [2:0]     delay_sel;
    logic [2:0][2:0] ev_sel;
    logic [2:0][2:0] tmo_sel;
  } mbrw_rt_cfg_t;

  typedef struct packed {
    logic nmi;
    logic acpi;
    logic rst;
    logic pwr;
  } mbrw_evt_t;

  typedef struct packed {
    logic [CNT_W-1:0] post_cnt;
    logic             post_done;
    logic             post_armed;
    mbrw_rt_t         rt_st;
    logic [1:0]       stage;
    logic [CNT_W-1:0] rt_cnt;
    mbrw_rt_cfg_t     cfg;
    mbrw_evt_t        evt;
  } mbrw_state_t;

endpackage

// ---- mbrw_tick.sv ----
`timescale 1ns/100ps
module mbrw_tick #(
  parameter int TICK_CYCLES = mbrw_pkg::TICK_CYCLES
) (
  input  wire logic clk_sys_i,  // system clock
  input  wire logic rst_n_i,    // sync reset, active low
  output logic      tick_o      // one-cycle pulse per millisecond
);
  import mbrw_pkg::*;

  logic [TICK_CW-1:0] cnt_reg;
  logic               tick_reg;

  // ***********************************************************
  // free-running millisecond divider
  // ***********************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (cnt_reg == TICK_CW'(TICK_CYCLES - 1))
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      cnt_reg  <= cnt_reg + TICK_CW'(1);
      tick_reg <= 1'b0;
    end
  end

  assign tick_o = tick_reg;

endmodule // mbrw_tick

// ---- mbrw_watchdog.sv ----
`timescale 1ns/100ps
// How it works
// - boot-time timeout: off, 30s to 30min
// - boot-time dog counts in self test, resets unless a runtime stage expires on the same tick
// - option pauses boot dog during user wait
// - runtime modes: off, once, single, repeated
// - runtime dog armed at OS start pulse
// - one-time mode: first trigger disables dog
// - single mode: stages once, then disable
// - repeated mode: last stage repeats forever
// - selectable start delay before runtime active
// - stage one fires its event, never off
// - stage two fires its event or off
// - stage three fires its event or off, skipped whenever stage two is off
// - stage one timeout from eight choices
// - stages two, three share those choices
module mbrw_watchdog #(
  parameter int TICK_CYCLES = mbrw_pkg::TICK_CYCLES
) (
  input  wire logic                   clk_sys_i,    // system clock, 40 MHz
  input  wire logic                   rst_n_i,      // sync reset, active low
  input  wire mbrw_pkg::mbrw_post_cfg_t post_cfg_i, // boot-time settings
  input  wire logic                   post_run_i,   // self test in progress, level
  input  wire logic                   user_wait_i,  // boot popup / password wait
  input  wire mbrw_pkg::mbrw_rt_cfg_t rt_cfg_i,     // runtime settings
  input  wire logic                   os_start_i,   // pulse: os about to boot
  input  wire logic                   trigger_i,    // pulse: software trigger
  output mbrw_pkg::mbrw_evt_t         evt_o,        // one-cycle event pulses
  output logic                        post_armed_o, // boot-time dog counting
  output mbrw_pkg::mbrw_rt_t          rt_state_o,   // runtime state
  output logic [1:0]                  rt_stage_o    // current stage index
);
  import mbrw_pkg::*;

  mbrw_state_t      st_reg;
  mbrw_state_t      st_next;
  logic             tick;
  logic [CNT_W-1:0] post_lim;
  logic [CNT_W-1:0] delay_lim;
  logic [CNT_W-1:0] stage_lim;
  logic             post_pause;

  mbrw_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (tick)
  );

  // ***********************************************************
  // timeout lookups
  // ***********************************************************
  assign post_lim   = LONG_TMO_MS[post_cfg_i.tmo_sel];
  assign delay_lim  = LONG_TMO_MS[st_reg.cfg.delay_sel];
  assign stage_lim  = STAGE_TMO_MS[st_reg.cfg.tmo_sel[st_reg.stage]];
  assign post_pause = post_cfg_i.stop_en && user_wait_i;

  // fire one event pulse by code
  function automatic mbrw_evt_t fire(input logic [2:0] code, input logic first);
    mbrw_evt_t e;
    e = '0;
    case (code)
      MBRW_EV_NMI:  e.nmi  = 1'b1;
      MBRW_EV_ACPI: e.acpi = 1'b1;
      MBRW_EV_RST:  e.rst  = 1'b1;
      MBRW_EV_PWR:  e.pwr  = 1'b1;
      MBRW_EV_OFF:  e.nmi  = first;
      default:      e.nmi  = first;
    endcase
    return e;
  endfunction

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    st_next     = st_reg;
    st_next.evt = '0;

    // boot-time dog
    if (!post_run_i || post_lim == TMO_NONE_MS)
    begin
      st_next.post_cnt   = CNT_RST;
      st_next.post_done  = 1'b0;
      st_next.post_armed = 1'b0;
    end
    else if (!st_reg.post_done)
    begin
      st_next.post_armed = !post_pause;
      if (tick && !post_pause)
      begin
        if (st_reg.post_cnt >= post_lim - CNT_W'(1))
        begin
          st_next.evt.rst    = 1'b1;
          st_next.post_done  = 1'b1;
          st_next.post_armed = 1'b0;
        end
        else
        begin
          st_next.post_cnt = st_reg.post_cnt + CNT_W'(1);
        end
      end
    end

    // runtime dog
    case (st_reg.rt_st)
      MBRW_RT_OFF:
      begin
        st_next.stage  = STAGE_RST;
        st_next.rt_cnt = CNT_RST;
      end
      MBRW_RT_DELAY:
      begin
        if (delay_lim == TMO_NONE_MS)
        begin
          st_next.rt_st = MBRW_RT_STAGE;
        end
        else if (tick)
        begin
          if (st_reg.rt_cnt >= delay_lim - CNT_W'(1))
          begin
            st_next.rt_st  = MBRW_RT_STAGE;
            st_next.rt_cnt = CNT_RST;
          end
          else
          begin
            st_next.rt_cnt = st_reg.rt_cnt + CNT_W'(1);
          end
        end
      end
      MBRW_RT_STAGE:
      begin
        if (trigger_i)
        begin
          st_next.stage  = STAGE_RST;
          st_next.rt_cnt = CNT_RST;
          if (st_reg.cfg.mode == MBRW_MODE_ONCE)
          begin
            st_next.rt_st = MBRW_RT_OFF;
          end
        end
        else if (tick)
        begin
          if (st_reg.rt_cnt >= stage_lim - CNT_W'(1))
          begin
            st_next.evt    = fire(st_reg.cfg.ev_sel[st_reg.stage],
                                  st_reg.stage == STAGE_RST);
            st_next.rt_cnt = CNT_RST;
            if (st_reg.stage != STAGE_LST &&
                st_reg.cfg.ev_sel[st_reg.stage + 2'd1] != MBRW_EV_OFF)
            begin
              st_next.stage = st_reg.stage + 2'd1;
            end
            else if (st_reg.cfg.mode != MBRW_MODE_REPEAT)
            begin
              // stage index drops with the last event, not a cycle later
              st_next.rt_st = MBRW_RT_OFF;
              st_next.stage = STAGE_RST;
            end
            else
            begin
              st_next.stage = st_reg.stage;
            end
          end
          else
          begin
            st_next.rt_cnt = st_reg.rt_cnt + CNT_W'(1);
          end
        end
      end
      default:
      begin
        st_next.rt_st = MBRW_RT_OFF;
      end
    endcase

    // arming just before the os boots; latches the settings
    if (os_start_i)
    begin
      st_next.cfg    = rt_cfg_i;
      st_next.stage  = STAGE_RST;
      st_next.rt_cnt = CNT_RST;
      st_next.rt_st  = (rt_cfg_i.mode == MBRW_MODE_OFF) ? MBRW_RT_OFF
                                                        : MBRW_RT_DELAY;
    end
  end

  // ***********************************************************
  // state register
  // ***********************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      st_reg       <= '0;
      st_reg.rt_st <= MBRW_RT_OFF;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign evt_o        = st_reg.evt;
  assign post_armed_o = st_reg.post_armed;
  assign rt_state_o   = st_reg.rt_st;
  assign rt_stage_o   = st_reg.stage;

endmodule // mbrw_watchdog

// ---- mbrw_watchdog_props.sv ----
`timescale 1ns/100ps
module mbrw_watchdog_props
  import mbrw_pkg::*;
#(
  parameter int TICK_CYCLES = mbrw_pkg::TICK_CYCLES
) (
  input wire logic           clk_sys_i,    // clock
  input wire logic           rst_n_i,      // sync reset
  input wire mbrw_post_cfg_t post_cfg_i,   // boot settings
  input wire logic           post_run_i,   // self test running
  input wire logic           user_wait_i,  // user wait
  input wire mbrw_rt_cfg_t   rt_cfg_i,     // runtime settings
  input wire logic           os_start_i,   // arm pulse
  input wire logic           trigger_i,    // trigger pulse
  input wire mbrw_evt_t      evt_o,        // events
  input wire logic           post_armed_o, // boot dog counting
  input wire mbrw_rt_t       rt_state_o,   // runtime state
  input wire logic [1:0]     rt_stage_o    // stage index
);
  // ***********************************************************
  // properties
  // ***********************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_evt_onehot: assert property ($onehot0(evt_o))
    else $error("two events at once");
  chk_arm_on: assert property (os_start_i && rt_cfg_i.mode != MBRW_MODE_OFF
    |=> rt_state_o == MBRW_RT_DELAY) else $error("arm not taken");
  chk_arm_off: assert property (os_start_i && rt_cfg_i.mode == MBRW_MODE_OFF
    |=> rt_state_o == MBRW_RT_OFF) else $error("off mode armed");
  chk_no_delay: assert property (os_start_i && rt_cfg_i.mode != MBRW_MODE_OFF
    && rt_cfg_i.delay_sel == 3'h0 ##1 !os_start_i |=> rt_state_o == MBRW_RT_STAGE)
    else $error("zero delay not skipped");
  chk_trig_rst: assert property (trigger_i && !os_start_i && rt_state_o == MBRW_RT_STAGE
    |=> rt_stage_o == 2'h0 && evt_o == 4'h0) else $error("trigger not restarting");
  chk_stage_evt: assert property ($changed(rt_stage_o) && !$past(trigger_i)
    && !$past(os_start_i) |-> evt_o != 4'h0) else $error("stage moved without event");
  chk_rt_src: assert property (evt_o.nmi || evt_o.acpi || evt_o.pwr
    |-> $past(rt_state_o) == MBRW_RT_STAGE) else $error("event outside stage");
  chk_boot_pause: assert property ((post_run_i && post_cfg_i.stop_en && user_wait_i)[*2]
    |-> !post_armed_o) else $error("boot dog not paused");
  chk_boot_idle: assert property ((!post_run_i)[*2] |-> !post_armed_o)
    else $error("boot dog armed outside self test");
endmodule // mbrw_watchdog_props

bind mbrw_watchdog mbrw_watchdog_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.clk_sys_i,
  .rst_n_i, .post_cfg_i, .post_run_i, .user_wait_i, .rt_cfg_i, .os_start_i, .trigger_i,
  .evt_o, .post_armed_o, .rt_state_o, .rt_stage_o);

// ---- tb_mbrw_watchdog.sv ----
`timescale 1ns/100ps
module tb_mbrw_watchdog;
  import mbrw_pkg::*;
  localparam int TK = 2;
  typedef struct packed {
    mbrw_mode_t      m;
    logic [2:0][2:0] ev;
    logic [2:0][2:0] tm;
    logic [2:0][1:0] si;
    logic [1:0]      n;
    logic [2:0][3:0] ex;
    mbrw_rt_t        fin;
  } mbrw_row_t;
  // ***********************************************************
  // stimulus table: mode, events, timeouts, event stages, count
  // ***********************************************************
  mbrw_row_t rows [4] = '{
    '{MBRW_MODE_SINGLE, {MBRW_EV_RST, MBRW_EV_ACPI, MBRW_EV_NMI}, 9'h008, 6'h24, 2'h3,
      12'h248, MBRW_RT_OFF},
    '{MBRW_MODE_REPEAT, {MBRW_EV_NMI, MBRW_EV_OFF, MBRW_EV_PWR}, 9'h002, 6'h00, 2'h2,
      12'h111, MBRW_RT_STAGE},
    '{MBRW_MODE_SINGLE, {MBRW_EV_NMI, MBRW_EV_OFF, MBRW_EV_ACPI}, 9'h000, 6'h00, 2'h1,
      12'h004, MBRW_RT_OFF},
    '{MBRW_MODE_OFF, 9'h000, 9'h000, 6'h00, 2'h0, 12'h000, MBRW_RT_OFF}};
  logic           clk_sys_i   = 1'b0;
  logic           rst_n_i     = 1'b0;
  mbrw_post_cfg_t post_cfg_i  = '0;
  logic           post_run_i  = 1'b0;
  logic           user_wait_i = 1'b0;
  mbrw_rt_cfg_t   rt_cfg_i    = '0;
  logic           os_start_i  = 1'b0;
  logic           trigger_i   = 1'b0;
  mbrw_evt_t      evt_o;
  logic           post_armed_o;
  mbrw_rt_t       rt_state_o;
  logic [1:0]     rt_stage_o;
  int             n_mismatch  = 0;
  int             total_checks = 0;

  mbrw_watchdog #(.TICK_CYCLES(TK)) i_dut (.clk_sys_i, .rst_n_i, .post_cfg_i, .post_run_i,
    .user_wait_i, .rt_cfg_i, .os_start_i, .trigger_i, .evt_o, .post_armed_o, .rt_state_o,
    .rt_stage_o);

  initial
  begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask

  task automatic check(input logic [20:0] seen, input logic [20:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_evt(input int lim, output int cyc);
    cyc = 0;
    do
    begin
      step(1);
      cyc++;
    end while (evt_o === 4'h0 && cyc < lim);
  endtask

  task automatic arm(input mbrw_rt_cfg_t c);
    rt_cfg_i = c;
    os_start_i = 1'b1;
    step(1);
    os_start_i = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(100000 * 25);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    int         cyc;
    logic [20:0] lim;
    step(6);
    rst_n_i = 1'b1;
    check({evt_o, post_armed_o, rt_state_o}, 21'h0, "reset");
    foreach (rows[k])
    begin
      arm('{rows[k].m, 3'h0, rows[k].ev, rows[k].tm});
      for (int i = 0; i < rows[k].n; i++)
      begin
        check(rt_stage_o, rows[k].si[i], "stage");
        wait_evt(5000, cyc);
        check(evt_o, rows[k].ex[i], "event");
        lim = STAGE_TMO_MS[rows[k].tm[rows[k].si[i]]];
        check(cyc >= (lim - 1) * TK && cyc <= lim * TK + 4, 21'h1, "span");
      end
      step(3);
      check(rt_state_o, rows[k].fin, "end state");
      $display("row %0d done", k);
    end
    // one-time mode: first trigger disarms
    arm('{MBRW_MODE_ONCE, 3'h0, 9'h001, 9'h000});
    step(10);
    trigger_i = 1'b1;
    step(1);
    trigger_i = 1'b0;
    step(1);
    check(rt_state_o, MBRW_RT_OFF, "once state");
    // trigger mid-stage restarts the count
    arm('{MBRW_MODE_SINGLE, 3'h0, 9'h001, 9'h000});
    step(800);
    trigger_i = 1'b1;
    step(1);
    trigger_i = 1'b0;
    wait_evt(5000, cyc);
    check(cyc >= 996 && cyc <= 1004, 21'h1, "restart span");
    $display("trigger tests done");
    // boot dog: disabled code, pause, expiry
    post_cfg_i = '{3'h7, 1'b1};
    post_run_i = 1'b1;
    step(4);
    check(post_armed_o, 1'b0, "boot off");
    post_cfg_i = '{3'h1, 1'b1};
    step(4);
    check(post_armed_o, 1'b1, "boot armed");
    user_wait_i = 1'b1;
    step(100);
    check(post_armed_o, 1'b0, "boot paused");
    user_wait_i = 1'b0;
    wait_evt(61000, cyc);
    check(evt_o, 4'h2, "boot reset");
    check(cyc >= 59990 && cyc <= 60006, 21'h1, "boot span");
    step(2);
    check(post_armed_o, 1'b0, "boot done");
    $display("boot tests done");
    final_report();
  end
endmodule // tb_mbrw_watchdog
